// ### dv/rbw_i2c_host.sv
`timescale 1ns/1ps
`default_nettype none

// serial bus master standing in for the host processor
module rbw_i2c_host (
    input wire logic clk_i,
    input wire logic sda_i,
    output var logic scl_o,
    output var logic sda_oe_o
);
    int half_n = 5;

    // bus idle: both lines released
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic half();
        repeat (half_n) @(posedge clk_i);
    endtask : half

    // start or repeated start, ends with clock low
    task automatic start();
        sda_oe_o <= 1'b0;
        half();
        scl_o <= 1'b1;
        half();
        sda_oe_o <= 1'b1;
        half();
        scl_o <= 1'b0;
        half();
    endtask : start

    task automatic stop();
        sda_oe_o <= 1'b1;
        half();
        scl_o <= 1'b1;
        half();
        sda_oe_o <= 1'b0;
        half();
    endtask : stop

    // one bit, data set while clock low, sampled at end of clock high
    task automatic bit_io(input logic b, output logic r);
        sda_oe_o <= ~b;
        half();
        scl_o <= 1'b1;
        half();
        r = sda_i;
        scl_o <= 1'b0;
        half();
    endtask : bit_io

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : put_byte

    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask : get_byte

    // index byte then n data bytes, msb byte of d first
    task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [23:0] d,
                      input int n, output logic ack);
        logic k;
        start();
        put_byte({a, 1'b0}, ack);
        put_byte(idx, k);
        ack = ack & k;
        for (int i = 0; i < n; i++) begin
            put_byte(d[23-8*i -: 8], k);
            ack = ack & k;
        end
        stop();
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d);
        logic k;
        start();
        put_byte({a, 1'b0}, k);
        put_byte(idx, k);
        start();
        put_byte({a, 1'b1}, k);
        get_byte(1'b1, d);
        stop();
    endtask : rd
endmodule : rbw_i2c_host

`default_nettype wire

// ### dv/tb_relay_board_watchdog_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_relay_board_watchdog_control;
    localparam int unsigned WD = 600;
    localparam logic [6:0] ADDR = 7'h2a;
    logic clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [1:0] grp = 2'b11;
    logic scl, host_oe, dut_sda, dut_oe, uv, shut, pump, hb_ind, trip;
    logic ind_cell, ind_perm, ind_zs, ind_sc, ind_shut, hb = 1'b0, hb_q = 1'b0;
    logic [2:0] heater;
    logic [7:0] valve;
    int n_mismatch = 0, n_compared = 0, cyc = 0, since_hb = 0;
    wire sda_w;

    // open drain wire with pull-up
    assign sda_w = ~host_oe & (~dut_oe | dut_sda);

    always #50 clk_i = ~clk_i;
    always #7.5 link_clk_i = ~link_clk_i;

    rbw_top #(.WDOG_CYCLES(WD)) i_rbw_top (
        .clk_i(clk_i), .srst_i(srst_i), .link_clk_i(link_clk_i), .scl_i(scl),
        .sda_i(sda_w), .sda_o(dut_sda), .sda_oe_o(dut_oe), .valve_grp_fitted_i(grp),
        .heater_o(heater), .valve_o(valve), .uv_lamp_o(uv), .lamp_shutter_o(shut),
        .pump_o(pump), .heartbeat_indicator_o(hb_ind), .cell_heater_indicator_o(ind_cell),
        .perm_tube_heater_indicator_o(ind_perm), .zero_span_valve_indicator_o(ind_zs),
        .sample_cal_valve_indicator_o(ind_sc), .lamp_shutter_indicator_o(ind_shut),
        .wdog_trip_o(trip));

    rbw_i2c_host i_rbw_i2c_host (.clk_i(link_clk_i), .sda_i(sda_w), .scl_o(scl),
        .sda_oe_o(host_oe));

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    // cycles since heartbeat output last changed, plus hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        hb_q <= hb_ind;
        since_hb <= (hb_ind !== hb_q) ? 0 : since_hb + 1;
        if (cyc == 12000) begin
            $display("mismatch at %0t: timeout", $time);
            n_mismatch = n_mismatch + 1;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // write heater, valve, misc in one transfer; tog flips heartbeat
    task automatic cmd(input logic [2:0] h, input logic [7:0] v, input logic [2:0] m,
                       input logic tog);
        logic ack;
        hb = hb ^ tog;
        i_rbw_i2c_host.wr(ADDR, 8'h00, {5'b0, h, v, 4'b0, m, hb}, 3, ack);
        chk(8'(ack), 8'h01, "write ack");
        repeat (10) @(negedge clk_i);
    endtask : cmd

    task automatic chk_out(input logic [2:0] h, input logic [7:0] v, input logic [2:0] m);
        chk(8'(heater), 8'(h), "heater");
        chk(valve, v & {{4{grp[1]}}, {4{grp[0]}}}, "valve");
        chk(8'({pump, uv, shut}), 8'(m), "misc");
        chk(8'({ind_cell, ind_perm, ind_shut}), 8'({h[0], h[1], m[0]}), "heat ind");
        chk(8'({ind_zs, ind_sc}), 8'({v[0], v[1]}), "valve ind");
        chk(8'(hb_ind), 8'(hb), "heartbeat");
    endtask : chk_out

    task automatic t_cmd();
        for (int i = 0; i < 8; i++) begin
            cmd(i[2:0], {i[2:0], ~i[2:0], i[1:0]}, ~i[2:0], 1'b1);
            chk_out(i[2:0], {i[2:0], ~i[2:0], i[1:0]}, ~i[2:0]);
            chk(8'(trip), 8'h00, "no trip");
        end
        $display("test cmd done");
    endtask : t_cmd

    task automatic t_strap();
        @(posedge clk_i);
        grp <= 2'b01;
        cmd(3'b000, 8'hff, 3'b000, 1'b1);
        chk(valve, 8'h0f, "group 0 only");
        @(posedge clk_i);
        grp <= 2'b10;
        cmd(3'b000, 8'hff, 3'b000, 1'b1);
        chk(valve, 8'hf0, "group 1 only");
        @(posedge clk_i);
        grp <= 2'b11;
        $display("test strap done");
    endtask : t_strap

    task automatic t_read();
        logic [7:0] d;
        cmd(3'b101, 8'ha5, 3'b011, 1'b1);
        i_rbw_i2c_host.rd(ADDR, 8'h01, d);
        chk(d, 8'ha5, "read valve");
        i_rbw_i2c_host.rd(ADDR, 8'h03, d);
        chk(d, {6'b0, hb, 1'b0}, "read status");
        i_rbw_i2c_host.rd(ADDR, 8'h04, d);
        chk(d, 8'h00, "read unmapped");
        $display("test read done");
    endtask : t_read

    task automatic t_bad();
        logic ack;
        cmd(3'b010, 8'h02, 3'b001, 1'b1);
        i_rbw_i2c_host.wr(7'h2b, 8'h00, 24'h07ff0f, 3, ack);
        chk(8'(ack), 8'h00, "foreign address");
        i_rbw_i2c_host.wr(ADDR, 8'h05, 24'hff0000, 1, ack);
        chk(8'(ack), 8'h01, "reserved index ack");
        repeat (10) @(negedge clk_i);
        chk_out(3'b010, 8'h02, 3'b001);
        $display("test bad address done");
    endtask : t_bad

    task automatic t_wdog();
        int k;
        logic [7:0] d;
        cmd(3'b111, 8'hff, 3'b111, 1'b1);
        k = 0;
        while (since_hb < WD - 10 && k < WD) begin
            @(negedge clk_i);
            k++;
        end
        chk(8'(trip), 8'h00, "early trip");
        while (trip !== 1'b1 && k < WD + 200) begin
            @(negedge clk_i);
            k++;
        end
        chk(8'(since_hb > WD - 6 && since_hb < WD + 6), 8'h01, "trip time");
        chk_out(3'b000, 8'h00, 3'b100);
        i_rbw_i2c_host.rd(ADDR, 8'h03, d);
        chk(d, {6'b0, hb, 1'b1}, "read trip status");
        cmd(3'b111, 8'hff, 3'b111, 1'b0);
        chk(8'(trip), 8'h01, "trip held");
        chk_out(3'b000, 8'h00, 3'b100);
        cmd(3'b111, 8'hff, 3'b111, 1'b1);
        chk(8'(trip), 8'h00, "trip cleared");
        cmd(3'b011, 8'h3c, 3'b110, 1'b1);
        chk_out(3'b011, 8'h3c, 3'b110);
        $display("test watchdog done");
    endtask : t_wdog

    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (5) @(negedge clk_i);
        chk_out(3'b000, 8'h00, 3'b000);
        chk(8'({trip, dut_oe}), 8'h00, "reset idle");
        $display("test reset done");
        t_cmd();
        t_strap();
        t_read();
        t_bad();
        t_wdog();
        end_sim();
    end
endmodule : tb_relay_board_watchdog_control

`default_nettype wire

// ### src/rbw_defs.svh
`ifndef RBW_DEFS_SVH
`define RBW_DEFS_SVH

// bus address of the board, value arbitrary
`define RBW_I2C_ADDR 7'h2a

// register indices seen over the serial bus, and the value heat and valve are loaded with on a trip
`define RBW_REG_HEAT 8'h00
`define RBW_REG_VALVE 8'h01
`define RBW_REG_MISC 8'h02
`define RBW_REG_STAT 8'h03
`define RBW_REG_RST 8'h00

// heater register fields
`define RBW_HEAT_CELL 0
`define RBW_HEAT_PERM 1
`define RBW_HEAT_AUX 2

// misc register fields
`define RBW_MISC_HB 0
`define RBW_MISC_SHUT 1
`define RBW_MISC_UV 2
`define RBW_MISC_PUMP 3

// valve register fields
`define RBW_VLV_ZS 0
`define RBW_VLV_SC 1

// status register fields
`define RBW_STAT_TRIP 0
`define RBW_STAT_HB 1

// timing
`define RBW_CLK_HZ 10000000
`define RBW_WDOG_TIME_S 30
`define RBW_WDOG_CYCLES (`RBW_WDOG_TIME_S * `RBW_CLK_HZ)

`endif

// ### src/rbw_pkg.sv
package rbw_pkg;

    typedef enum logic [2:0] {
        L_IDLE,
        L_ADDR,
        L_ACK_A,
        L_WDATA,
        L_ACK_W,
        L_RDATA,
        L_ACK_R
    } rbw_i2c_st_t;

    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] dat;
    } rbw_wr_t;

    typedef struct packed {
        rbw_i2c_st_t st;
        logic [3:0] bitc;
        logic [7:0] sh;
        logic rw;
        logic first;
        logic [7:0] ptr;
        logic [7:0] heat;
        logic [7:0] valve;
        logic [7:0] misc;
        rbw_wr_t wr;
        logic wr_tgl;
        logic sda_oe;
        logic sda_d;
        logic scl_q;
        logic sda_q;
    } rbw_link_t;

    typedef struct packed {
        logic [2:0] heater;
        logic [7:0] valve;
        logic shutter;
        logic uv;
        logic pump;
        logic hb;
        logic ind_cell;
        logic ind_perm;
        logic ind_zs;
        logic ind_sc;
        logic ind_shut;
        logic trip;
    } rbw_out_t;

    typedef struct packed {
        logic [7:0] heat;
        logic [7:0] valve;
        logic [7:0] misc;
        logic trip;
        logic tgl_q;
        rbw_out_t out;
    } rbw_sys_t;

endpackage : rbw_pkg

// ### src/rbw_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rbw_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rbw_sync_st_t;

    rbw_sync_st_t s;
    rbw_sync_st_t next_s;

    always_comb begin
        next_s.s1 = d_i;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    assign q_o = s.s2;

endmodule : rbw_sync

`default_nettype wire

// ### src/rbw_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rbw_defs.svh"

module rbw_top #(
    parameter int unsigned WDOG_CYCLES = `RBW_WDOG_CYCLES
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [1:0] valve_grp_fitted_i,
    output logic [2:0] heater_o,
    output logic [7:0] valve_o,
    output logic uv_lamp_o,
    output logic lamp_shutter_o,
    output logic pump_o,
    output logic heartbeat_indicator_o,
    output logic cell_heater_indicator_o,
    output logic perm_tube_heater_indicator_o,
    output logic zero_span_valve_indicator_o,
    output logic sample_cal_valve_indicator_o,
    output logic lamp_shutter_indicator_o,
    output logic wdog_trip_o
);

    rbw_pkg::rbw_link_t l;
    rbw_pkg::rbw_link_t next_l;
    rbw_pkg::rbw_sys_t s;
    rbw_pkg::rbw_sys_t next_s;

    logic lrst;
    logic scl_s;
    logic sda_s;
    logic trip_l;
    logic tgl_s;
    logic [1:0] fit_s;
    logic expired;
    logic scl_rise;
    logic scl_fall;
    logic [7:0] rd_val;
    logic [7:0] rd_nxt;
    logic [7:0] stat;
    logic wr_evt;
    logic hb_chg;

    // link-side synchronisers
    rbw_sync #(.W(1)) u_sync_rst (
        .clk_i(link_clk_i),
        .d_i(srst_i),
        .q_o(lrst)
    );

    rbw_sync #(.W(2)) u_sync_bus (
        .clk_i(link_clk_i),
        .d_i({scl_i, sda_i}),
        .q_o({scl_s, sda_s})
    );

    rbw_sync #(.W(1)) u_sync_trip (
        .clk_i(link_clk_i),
        .d_i(s.trip),
        .q_o(trip_l)
    );

    // system-side synchronisers
    rbw_sync #(.W(1)) u_sync_tgl (
        .clk_i(clk_i),
        .d_i(l.wr_tgl),
        .q_o(tgl_s)
    );

    rbw_sync #(.W(2)) u_sync_fit (
        .clk_i(clk_i),
        .d_i(valve_grp_fitted_i),
        .q_o(fit_s)
    );

    rbw_wdog #(.LIMIT(WDOG_CYCLES)) u_wdog (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .hb_i(s.misc[`RBW_MISC_HB]),
        .expired_o(expired)
    );

    function automatic logic [7:0] rbw_rd(input logic [7:0] p, input logic [7:0] h,
                                          input logic [7:0] v, input logic [7:0] m,
                                          input logic [7:0] st);
        logic [7:0] r;
        r = 8'h00;
        unique case (p)
            `RBW_REG_HEAT: r = h;
            `RBW_REG_VALVE: r = v;
            `RBW_REG_MISC: r = m;
            `RBW_REG_STAT: r = st;
            default: r = 8'h00;
        endcase
        return r;
    endfunction : rbw_rd

    // i2c slave on the link clock
    always_comb begin
        next_l = l;
        next_l.scl_q = scl_s;
        next_l.sda_q = sda_s;
        next_l.sda_d = 1'b0;
        scl_rise = scl_s && !l.scl_q;
        scl_fall = !scl_s && l.scl_q;
        stat = 8'h00;
        stat[`RBW_STAT_TRIP] = trip_l;
        stat[`RBW_STAT_HB] = l.misc[`RBW_MISC_HB];
        rd_val = rbw_rd(l.ptr, l.heat, l.valve, l.misc, stat);
        rd_nxt = rbw_rd(l.ptr + 8'h01, l.heat, l.valve, l.misc, stat);
        if (scl_s && l.scl_q && l.sda_q && !sda_s) begin
            next_l.st = rbw_pkg::L_ADDR;
            next_l.bitc = 4'h0;
            next_l.sda_oe = 1'b0;
        end else if (scl_s && l.scl_q && !l.sda_q && sda_s) begin
            next_l.st = rbw_pkg::L_IDLE;
            next_l.sda_oe = 1'b0;
        end else if (scl_rise) begin
            unique case (l.st)
                rbw_pkg::L_ADDR, rbw_pkg::L_WDATA: begin
                    next_l.sh = {l.sh[6:0], sda_s};
                    next_l.bitc = l.bitc + 4'h1;
                end
                rbw_pkg::L_RDATA: begin
                    next_l.sh = {l.sh[6:0], 1'b0};
                    next_l.bitc = l.bitc + 4'h1;
                end
                rbw_pkg::L_ACK_R: begin
                    if (!sda_s) begin
                        next_l.ptr = l.ptr + 8'h01;
                        next_l.sh = rd_nxt;
                        next_l.bitc = 4'h0;
                        next_l.st = rbw_pkg::L_RDATA;
                    end else begin
                        next_l.st = rbw_pkg::L_IDLE;
                    end
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            unique case (l.st)
                rbw_pkg::L_ADDR: begin
                    if (l.bitc == 4'h8) begin
                        if (l.sh[7:1] == `RBW_I2C_ADDR) begin
                            next_l.st = rbw_pkg::L_ACK_A;
                            next_l.sda_oe = 1'b1;
                            next_l.rw = l.sh[0];
                        end else begin
                            next_l.st = rbw_pkg::L_IDLE;
                        end
                    end
                end
                rbw_pkg::L_ACK_A: begin
                    next_l.bitc = 4'h0;
                    if (l.rw) begin
                        next_l.st = rbw_pkg::L_RDATA;
                        next_l.sh = rd_val;
                        next_l.sda_oe = !rd_val[7];
                    end else begin
                        next_l.st = rbw_pkg::L_WDATA;
                        next_l.first = 1'b1;
                        next_l.sda_oe = 1'b0;
                    end
                end
                rbw_pkg::L_WDATA: begin
                    if (l.bitc == 4'h8) begin
                        next_l.st = rbw_pkg::L_ACK_W;
                        next_l.sda_oe = 1'b1;
                        if (l.first) begin
                            next_l.ptr = l.sh;
                            next_l.first = 1'b0;
                        end else begin
                            unique case (l.ptr)
                                `RBW_REG_HEAT: next_l.heat = l.sh;
                                `RBW_REG_VALVE: next_l.valve = l.sh;
                                `RBW_REG_MISC: next_l.misc = l.sh;
                                default: ;
                            endcase
                            next_l.wr.idx = l.ptr;
                            next_l.wr.dat = l.sh;
                            next_l.wr_tgl = !l.wr_tgl;
                            next_l.ptr = l.ptr + 8'h01;
                        end
                    end
                end
                rbw_pkg::L_ACK_W: begin
                    next_l.st = rbw_pkg::L_WDATA;
                    next_l.bitc = 4'h0;
                    next_l.sda_oe = 1'b0;
                end
                rbw_pkg::L_RDATA: begin
                    if (l.bitc == 4'h8) begin
                        next_l.st = rbw_pkg::L_ACK_R;
                        next_l.sda_oe = 1'b0;
                    end else begin
                        next_l.sda_oe = !l.sh[7];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (lrst) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // system side: commands, watchdog trip, outputs
    always_comb begin
        next_s = s;
        wr_evt = tgl_s != s.tgl_q;
        next_s.tgl_q = tgl_s;
        if (wr_evt) begin
            unique case (l.wr.idx)
                `RBW_REG_HEAT: next_s.heat = l.wr.dat;
                `RBW_REG_VALVE: next_s.valve = l.wr.dat;
                `RBW_REG_MISC: next_s.misc = l.wr.dat;
                default: ;
            endcase
        end
        hb_chg = next_s.misc[`RBW_MISC_HB] != s.misc[`RBW_MISC_HB];
        if (expired) begin
            next_s.trip = 1'b1;
        end
        if (hb_chg) begin
            next_s.trip = 1'b0;
        end
        if (expired && !s.trip && !hb_chg) begin
            next_s.heat = `RBW_REG_RST;
            next_s.valve = `RBW_REG_RST;
            next_s.misc[`RBW_MISC_SHUT] = 1'b0;
            next_s.misc[`RBW_MISC_UV] = 1'b0;
        end
        next_s.out.heater = next_s.trip ? 3'h0 : next_s.heat[2:0];
        next_s.out.valve = next_s.trip ? 8'h00 :
            next_s.valve & {{4{fit_s[1]}}, {4{fit_s[0]}}};
        next_s.out.shutter = !next_s.trip && next_s.misc[`RBW_MISC_SHUT];
        next_s.out.uv = !next_s.trip && next_s.misc[`RBW_MISC_UV];
        next_s.out.pump = next_s.misc[`RBW_MISC_PUMP];
        next_s.out.hb = next_s.misc[`RBW_MISC_HB];
        next_s.out.ind_cell = next_s.out.heater[`RBW_HEAT_CELL];
        next_s.out.ind_perm = next_s.out.heater[`RBW_HEAT_PERM];
        next_s.out.ind_zs = next_s.out.valve[`RBW_VLV_ZS];
        next_s.out.ind_sc = next_s.out.valve[`RBW_VLV_SC];
        next_s.out.ind_shut = next_s.out.shutter;
        next_s.out.trip = next_s.trip;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sda_o = l.sda_d;
    assign sda_oe_o = l.sda_oe;
    assign heater_o = s.out.heater;
    assign valve_o = s.out.valve;
    assign uv_lamp_o = s.out.uv;
    assign lamp_shutter_o = s.out.shutter;
    assign pump_o = s.out.pump;
    assign heartbeat_indicator_o = s.out.hb;
    assign cell_heater_indicator_o = s.out.ind_cell;
    assign perm_tube_heater_indicator_o = s.out.ind_perm;
    assign zero_span_valve_indicator_o = s.out.ind_zs;
    assign sample_cal_valve_indicator_o = s.out.ind_sc;
    assign lamp_shutter_indicator_o = s.out.ind_shut;
    assign wdog_trip_o = s.out.trip;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    trip_sets_a: assert property ($rose(expired) && !hb_chg |=> wdog_trip_o)
        else $error("trip not raised after expiry");
    trip_clears_a: assert property (wdog_trip_o && hb_chg |=> !wdog_trip_o)
        else $error("trip not released on heartbeat edge");
    trip_forces_off_a: assert property (wdog_trip_o |->
        heater_o == 3'h0 && valve_o == 8'h00 && !uv_lamp_o && !lamp_shutter_o)
        else $error("outputs active while tripped");
    pump_untouched_a: assert property (pump_o == s.misc[`RBW_MISC_PUMP])
        else $error("pump drive altered");
    valve_write_a: assert property (
        wr_evt && l.wr.idx == `RBW_REG_VALVE && !expired && !s.trip && fit_s == 2'h3
        && $stable(fit_s) |=> valve_o == $past(l.wr.dat))
        else $error("valve command not applied");
    group_gate_a: assert property (!fit_s[0] && !$past(fit_s[0]) |-> valve_o[3:0] == 4'h0)
        else $error("unfitted valve group driven");
    heat_ind_a: assert property (cell_heater_indicator_o == heater_o[`RBW_HEAT_CELL]
        && perm_tube_heater_indicator_o == heater_o[`RBW_HEAT_PERM]
        && lamp_shutter_indicator_o == lamp_shutter_o)
        else $error("heater or shutter indicator mismatch");
    zs_ind_a: assert property (zero_span_valve_indicator_o == valve_o[`RBW_VLV_ZS])
        else $error("zero span indicator mismatch");
    sc_ind_a: assert property (sample_cal_valve_indicator_o == valve_o[`RBW_VLV_SC])
        else $error("sample cal indicator mismatch");
    trip_holds_a: assert property (wdog_trip_o && !hb_chg |=> wdog_trip_o)
        else $error("trip released without heartbeat edge");
    ack_state_a: assert property (@(posedge link_clk_i) disable iff (lrst)
        sda_oe_o |-> l.st inside {rbw_pkg::L_ACK_A, rbw_pkg::L_ACK_W, rbw_pkg::L_RDATA})
        else $error("sda driven outside ack or read");

    trip_seen_c: cover property ($rose(wdog_trip_o));
    trip_clear_c: cover property ($fell(wdog_trip_o));
    write_seen_c: cover property (wr_evt && l.wr.idx == `RBW_REG_MISC);
    read_seen_c: cover property (@(posedge link_clk_i) disable iff (lrst)
        l.st == rbw_pkg::L_ACK_R && scl_rise && !sda_s);

endmodule : rbw_top

`default_nettype wire

// ### src/rbw_wdog.sv
`timescale 1ns/1ps
`default_nettype none

module rbw_wdog #(
    parameter int unsigned LIMIT = 300000000
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic hb_i,
    output logic expired_o
);

    typedef struct packed {
        logic hb_q;
        logic [31:0] cnt;
        logic expired;
    } rbw_wdog_st_t;

    rbw_wdog_st_t s;
    rbw_wdog_st_t next_s;
    logic chg;

    always_comb begin
        next_s = s;
        chg = hb_i != s.hb_q;
        next_s.hb_q = hb_i;
        if (chg) begin
            next_s.cnt = 32'h0;
        end else if (s.cnt != LIMIT) begin
            next_s.cnt = s.cnt + 32'h1;
        end
        next_s.expired = !chg && (next_s.cnt == LIMIT);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // masked as soon as a new heartbeat level shows, so a cleared trip is not re-armed
    assign expired_o = s.expired && (hb_i == s.hb_q);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    restart_on_edge_a: assert property (chg |=> s.cnt == 32'h0)
        else $error("count not restarted on heartbeat edge");
    expire_at_limit_a: assert property (
        (s.cnt == LIMIT - 1) && !chg && (hb_i == s.hb_q) ##1 (hb_i == s.hb_q) |=> s.expired)
        else $error("watchdog did not expire at limit");
    no_early_expiry_a: assert property ((s.cnt < LIMIT) |-> !expired_o)
        else $error("watchdog expired early");

endmodule : rbw_wdog

`default_nettype wire
